// ===== design/sfq_pkg.sv
// Constants shared by the sensor queue capture block.
package sfq_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] SFQ_IDX_DOWNS = 8'h45;
    localparam logic [7:0] SFQ_IDX_THRESH = 8'h46;
    localparam logic [7:0] SFQ_IDX_CAPT = 8'h47;
    localparam logic [7:0] SFQ_IDX_STAT = 8'h48;
    localparam logic [7:0] SFQ_IDX_MASK = 8'h49;
    localparam logic [7:0] SFQ_IDX_LEVEL = 8'h4a;
    localparam logic [7:0] SFQ_IDX_DATA = 8'h24;

    // ==========================================================
    // Reset values
    localparam logic [7:0] SFQ_DOWNS_RST = 8'h00;
    localparam logic [7:0] SFQ_THRESH_RST = 8'h80;
    localparam logic [7:0] SFQ_CAPT_RST = 8'h10;
    localparam logic [2:0] SFQ_MASK_RST = 3'h0;

    // ==========================================================
    // Field positions
    localparam int SFQ_GYR_DS_LSB = 0;
    localparam int SFQ_GYR_FILT = 3;
    localparam int SFQ_ACC_DS_LSB = 4;
    localparam int SFQ_ACC_FILT = 7;
    localparam int SFQ_GYR_EN = 7;
    localparam int SFQ_ACC_EN = 6;
    localparam int SFQ_MAG_EN = 5;
    localparam int SFQ_HDR_EN = 4;
    localparam int SFQ_TAG1_EN = 3;
    localparam int SFQ_TAG2_EN = 2;
    localparam int SFQ_TIME_EN = 1;
    localparam int SFQ_EV_WM = 0;
    localparam int SFQ_EV_FULL = 1;
    localparam int SFQ_EV_DROP = 2;

    // ==========================================================
    // Queue geometry and frame codes
    localparam int SFQ_AW = 10;
    localparam logic [10:0] SFQ_DEPTH = 11'd1024;
    localparam logic [2:0] SFQ_HDR_DATA = 3'b100;
    localparam logic [7:0] SFQ_HDR_TIME = 8'h44;
    localparam logic [7:0] SFQ_HDR_EMPTY = 8'h80;
    localparam logic [4:0] SFQ_SAMPLE_BYTES = 5'd6;

    typedef enum logic [0:0] {
        SFQ_IDLE = 1'b0,
        SFQ_PUSH = 1'b1
    } sfq_state_t;

endpackage : sfq_pkg

// ===== design/sfq_capture.sv
// Sensor queue capture, framing, watermark and AHB-Lite register slave.
// What this block does
// - Gyro keeps one of 2^N samples
// - Accel keeps one of 2^M samples
// - Filter select picks raw or filtered data
// - Watermark when level exceeds threshold words
// - Threshold register reads back
// - All captures off writes nothing
// - Gyro enable stores three gyro axes
// - Accel enable stores three accel axes
// - Mag enable stores three mag axes
// - Header enable prefixes each frame header
// - Per-pin tag enables mark frames
// - Time frame returned on over-read
// - Pin two polarity ignored for tags
`timescale 1ns/100ps
module sfq_capture
    import sfq_pkg::*;
(
    input wire logic hclk, // Bus clock, 100 MHz.
    input wire logic hresetn, // Asynchronous reset, active low.
    input wire logic hsel, // Slave select.
    input wire logic [31:0] haddr, // Byte address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write when high.
    input wire logic [2:0] hsize, // Transfer size, word only.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    output logic [31:0] hrdata, // Read data.
    output logic hreadyout, // Slave ready.
    output logic hresp, // Response, always OKAY.
    output logic irq, // Level interrupt.
    input wire logic gyr_valid, // Gyro sample strobe.
    input wire logic [47:0] gyr_raw, // Gyro pre-filter sample.
    input wire logic [47:0] gyr_filt, // Gyro filtered sample.
    input wire logic acc_valid, // Accel sample strobe.
    input wire logic [47:0] acc_raw, // Accel pre-filter sample.
    input wire logic [47:0] acc_filt, // Accel filtered sample.
    input wire logic mag_valid, // Mag sample strobe.
    input wire logic [47:0] mag_data, // Mag sample.
    input wire logic [23:0] sensor_time, // Sensor time counter.
    input wire logic event_pin_one, // First interrupt pin level.
    input wire logic event_pin_two // Second interrupt pin level.
);

    // ==========================================================
    // Helpers
    function automatic logic [6:0] ds_mask(input logic [2:0] n);
        logic [7:0] m;
        m = (8'h01 << n) - 8'h01;
        return m[6:0];
    endfunction : ds_mask

    // ==========================================================
    // Declarations
    logic [7:0] downs_q, downs_d, thresh_q, thresh_d, capt_q, capt_d;
    logic [2:0] stat_q, stat_d, mask_q, mask_d;
    logic irq_q, irq_d;
    logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
    logic [7:0] wr_idx_q, wr_idx_d, rd_idx_q, rd_idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q, hreadyout_d;
    logic hresp_q;
    logic [1:0] pin_s1_q, pin_s2_q;
    logic [1:0] ds_in, ds_take;
    logic [2:0] ds_n [2];
    logic gyr_t, acc_t, mag_t, any_t;
    logic [47:0] gyr_sel, acc_sel;
    logic [151:0] fb_buf;
    logic [4:0] fb_len;
    logic [7:0] fb_hdr;
    sfq_state_t st_q, st_d;
    logic [151:0] stage_q, stage_d;
    logic [4:0] left_q, left_d;
    logic [10:0] count_q, count_d;
    logic [SFQ_AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [2:0] ovr_q, ovr_d;
    logic [23:0] tlat_q, tlat_d;
    logic [7:0] mem [1024];
    logic acc_ph, wr_do, rd_do, rd_data, push, pop, drop_ev, full_ev, wm_cond;
    logic [7:0] rval, qbyte;
    logic [10:0] free;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end
        else
        begin
            pin_s1_q <= {event_pin_two, event_pin_one};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ==========================================================
    // Downsampling
    assign ds_n[0] = downs_q[SFQ_GYR_DS_LSB +: 3];
    assign ds_n[1] = downs_q[SFQ_ACC_DS_LSB +: 3];
    assign ds_in[0] = gyr_valid && capt_q[SFQ_GYR_EN];
    assign ds_in[1] = acc_valid && capt_q[SFQ_ACC_EN];

    genvar g;
    for (g = 0; g < 2; g++)
    begin : g_ds
        logic [6:0] cnt_q, cnt_d;
        always_comb
        begin
            cnt_d = cnt_q;
            if (ds_in[g])
                cnt_d = (cnt_q + 7'h01) & ds_mask(ds_n[g]);
        end
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
                cnt_q <= 7'h00;
            else
                cnt_q <= cnt_d;
        end
        assign ds_take[g] = ds_in[g] && (cnt_q == 7'h00);
    end

    // ==========================================================
    // Frame assembly
    // raw or filtered select
    assign gyr_sel = downs_q[SFQ_GYR_FILT] ? gyr_filt : gyr_raw;
    assign acc_sel = downs_q[SFQ_ACC_FILT] ? acc_filt : acc_raw;
    assign gyr_t = ds_take[0];
    assign acc_t = ds_take[1];
    assign mag_t = mag_valid && capt_q[SFQ_MAG_EN];
    assign any_t = gyr_t || acc_t || mag_t;

    always_comb
    begin
        fb_buf = '0;
        fb_len = 5'd0;
        // tags follow the raw pin level; pin polarity plays no part.
        fb_hdr = {SFQ_HDR_DATA, mag_t, gyr_t, acc_t,
                  pin_s2_q[0] && capt_q[SFQ_TAG1_EN],
                  pin_s2_q[1] && capt_q[SFQ_TAG2_EN]};
        if (capt_q[SFQ_HDR_EN])
        begin
            fb_buf[7:0] = fb_hdr;
            fb_len = 5'd1;
        end
        if (mag_t)
        begin
            fb_buf[{fb_len, 3'b000} +: 48] = mag_data;
            fb_len = fb_len + SFQ_SAMPLE_BYTES;
        end
        if (gyr_t)
        begin
            fb_buf[{fb_len, 3'b000} +: 48] = gyr_sel;
            fb_len = fb_len + SFQ_SAMPLE_BYTES;
        end
        if (acc_t)
        begin
            fb_buf[{fb_len, 3'b000} +: 48] = acc_sel;
            fb_len = fb_len + SFQ_SAMPLE_BYTES;
        end
    end

    // ==========================================================
    // Queue control
    // Only whole frames enter the queue, so a reader never sees a torn frame; a
    // frame that arrives while the previous one is still being pushed is dropped.
    assign rd_data = rd_do && (rd_idx_q == SFQ_IDX_DATA);
    assign pop = rd_data && (count_q != 11'd0);
    assign push = (st_q == SFQ_PUSH);
    assign free = SFQ_DEPTH - count_q;
    assign qbyte = mem[rptr_q];

    always_comb
    begin
        st_d = st_q;
        stage_d = stage_q;
        left_d = left_q;
        drop_ev = 1'b0;
        case (st_q)
            SFQ_IDLE:
            begin
                if (any_t && (free >= {6'h00, fb_len}))
                begin
                    stage_d = fb_buf;
                    left_d = fb_len;
                    st_d = SFQ_PUSH;
                end
                else if (any_t)
                    drop_ev = 1'b1;
            end
            SFQ_PUSH:
            begin
                stage_d = stage_q >> 8;
                left_d = left_q - 5'd1;
                if (left_q == 5'd1)
                    st_d = SFQ_IDLE;
                if (any_t)
                    drop_ev = 1'b1;
            end
            default: st_d = SFQ_IDLE;
        endcase
        count_d = count_q + {10'h000, push} - {10'h000, pop};
        wptr_d = push ? wptr_q + 10'h001 : wptr_q;
        rptr_d = pop ? rptr_q + 10'h001 : rptr_q;
        full_ev = (count_d == SFQ_DEPTH);
        ovr_d = ovr_q;
        tlat_d = tlat_q;
        if (count_q != 11'd0)
            ovr_d = 3'd0;
        else if (rd_data && capt_q[SFQ_TIME_EN] && (ovr_q != 3'd4))
        begin
            ovr_d = ovr_q + 3'd1;
            if (ovr_q == 3'd0)
                tlat_d = sensor_time;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= SFQ_IDLE;
            stage_q <= '0;
            left_q <= 5'd0;
            count_q <= 11'd0;
            wptr_q <= '0;
            rptr_q <= '0;
            ovr_q <= 3'd0;
            tlat_q <= 24'h000000;
        end
        else
        begin
            st_q <= st_d;
            stage_q <= stage_d;
            left_q <= left_d;
            count_q <= count_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            ovr_q <= ovr_d;
            tlat_q <= tlat_d;
        end
    end

    always_ff @(posedge hclk)
    begin
        if (push)
            mem[wptr_q] <= stage_q[7:0];
    end

    // ==========================================================
    // Bus slave
    // Reads take one wait state so a write in the preceding data phase is seen.
    assign acc_ph = hsel && hready && htrans[1];
    assign wr_do = wr_pend_q;
    assign rd_do = rd_pend_q;

    always_comb
    begin
        rval = 8'h00;
        case (rd_idx_q)
            SFQ_IDX_DOWNS: rval = downs_q;
            SFQ_IDX_THRESH: rval = thresh_q;
            SFQ_IDX_CAPT: rval = capt_q;
            SFQ_IDX_STAT: rval = {5'h00, stat_q};
            SFQ_IDX_MASK: rval = {5'h00, mask_q};
            SFQ_IDX_LEVEL: rval = count_q[10:3];
            SFQ_IDX_DATA:
            begin
                if (count_q != 11'd0)
                    rval = qbyte;
                else if (!capt_q[SFQ_TIME_EN])
                    rval = SFQ_HDR_EMPTY;
                else
                    case (ovr_q)
                        3'd0: rval = SFQ_HDR_TIME;
                        3'd1: rval = sensor_time[7:0];
                        3'd2: rval = tlat_q[15:8];
                        3'd3: rval = tlat_q[23:16];
                        default: rval = SFQ_HDR_EMPTY;
                    endcase
            end
            default: rval = 8'h00;
        endcase
        wr_pend_d = acc_ph && hwrite;
        rd_pend_d = acc_ph && !hwrite;
        wr_idx_d = acc_ph ? haddr[9:2] : wr_idx_q;
        rd_idx_d = acc_ph ? haddr[9:2] : rd_idx_q;
        hreadyout_d = !rd_pend_d;
        hrdata_d = rd_do ? {24'h000000, rval} : hrdata_q;
        downs_d = downs_q;
        thresh_d = thresh_q;
        capt_d = capt_q;
        mask_d = mask_q;
        if (wr_do)
            case (wr_idx_q)
                SFQ_IDX_DOWNS: downs_d = hwdata[7:0];
                SFQ_IDX_THRESH: thresh_d = hwdata[7:0];
                SFQ_IDX_CAPT: capt_d = {hwdata[7:1], 1'b0};
                SFQ_IDX_MASK: mask_d = hwdata[2:0];
                default: mask_d = mask_q;
            endcase
        wm_cond = ({1'b0, count_q[10:2]} > {2'b00, thresh_q});
        // A status event in the clearing cycle survives the write of one.
        stat_d = stat_q;
        if (wr_do && (wr_idx_q == SFQ_IDX_STAT))
            stat_d = stat_q & ~hwdata[2:0];
        stat_d[SFQ_EV_WM] = stat_d[SFQ_EV_WM] | wm_cond;
        stat_d[SFQ_EV_FULL] = stat_d[SFQ_EV_FULL] | full_ev;
        stat_d[SFQ_EV_DROP] = stat_d[SFQ_EV_DROP] | drop_ev;
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
            rd_idx_q <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h00000000;
            hresp_q <= 1'b0;
            downs_q <= SFQ_DOWNS_RST;
            thresh_q <= SFQ_THRESH_RST;
            capt_q <= SFQ_CAPT_RST;
            mask_q <= SFQ_MASK_RST;
            stat_q <= 3'h0;
            irq_q <= 1'b0;
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            wr_idx_q <= wr_idx_d;
            rd_idx_q <= rd_idx_d;
            hreadyout_q <= hreadyout_d;
            hrdata_q <= hrdata_d;
            hresp_q <= 1'b0;
            downs_q <= downs_d;
            thresh_q <= thresh_d;
            capt_q <= capt_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            irq_q <= irq_d;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign irq = irq_q;

endmodule : sfq_capture

// ===== verification/sfq_capture_asserts.sv
// Bus timing and interrupt checks for the sensor queue capture block.
`timescale 1ns/100ps
module sfq_capture_asserts
    import sfq_pkg::*;
(
    input wire logic hclk, // Clock.
    input wire logic hresetn, // Reset, active low.
    input wire logic hsel, // Select.
    input wire logic [31:0] haddr, // Address.
    input wire logic [1:0] htrans, // Transfer type.
    input wire logic hwrite, // Write flag.
    input wire logic [31:0] hwdata, // Write data.
    input wire logic hready, // Bus ready.
    input wire logic [31:0] hrdata, // Read data.
    input wire logic hreadyout, // Slave ready.
    input wire logic hresp, // Response.
    input wire logic irq // Interrupt.
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_q;
    logic wr_q;
    logic [7:0] idx_q;
    logic map_w;
    // The data phase view only moves while the bus is ready; the slave's pend flags update every cycle.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
        end
        else if (hready)
        begin
            rd_q <= hsel & htrans[1] & ~hwrite;
            wr_q <= hsel & htrans[1] & hwrite;
            idx_q <= haddr[9:2];
        end
    end
    assign map_w = idx_q inside {SFQ_IDX_DOWNS, SFQ_IDX_THRESH, SFQ_IDX_CAPT, SFQ_IDX_STAT,
        SFQ_IDX_MASK, SFQ_IDX_LEVEL, SFQ_IDX_DATA};
    property p_rd_wait;
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_nowait;
        hsel && hready && htrans[1] && hwrite |=> hreadyout;
    endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_hold;
        !$stable(hrdata) |-> !$past(hreadyout);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_upper;
        hrdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_unmapped;
        rd_q && !hreadyout && !map_w |=> hrdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reserved;
        rd_q && !hreadyout |=> (idx_q != SFQ_IDX_CAPT || !hrdata[0])
            && ((idx_q != SFQ_IDX_STAT && idx_q != SFQ_IDX_MASK) || hrdata[7:3] == 5'h00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_mask_off;
        wr_q && hready && idx_q == SFQ_IDX_MASK && hwdata[2:0] == 3'h0 |-> ##2 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked interrupt high");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response");
endmodule : sfq_capture_asserts

bind sfq_capture sfq_capture_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq);

// ===== verification/sfq_capture_bench.sv
// Self-checking bench for the sensor queue capture block.
`timescale 1ns/100ps
module sfq_capture_bench;
    import sfq_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, t;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic gyr_valid, acc_valid, mag_valid, event_pin_one, event_pin_two;
    logic [47:0] gyr_raw, gyr_filt, acc_raw, acc_filt, mag_data;
    logic [23:0] sensor_time;
    logic [7:0] capt, downs, w8;
    logic [7:0] q[$];
    logic [31:0] seed = 32'h0000871e;
    int failures, samples_checked, gcnt, acnt;
    assign hready = hreadyout;
    sfq_capture u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .irq, .gyr_valid, .gyr_raw, .gyr_filt, .acc_valid, .acc_raw,
        .acc_filt, .mag_valid, .mag_data, .sensor_time, .event_pin_one, .event_pin_two);
    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: seen %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // A slave that never answers ends the run here instead of hanging it.
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                failures++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {22'h000000, idx, 2'b00};
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        wait_rdy();
        t = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(t, {24'h000000, e});
    endtask : rd
    task automatic push6(input logic k, input logic [47:0] d);
        if (k)
            for (int i = 0; i < 6; i++)
                q.push_back(d[8*i +: 8]);
    endtask : push6
    // Models one strobe; the wait covers the longest frame push.
    task automatic strobe(input logic g, input logic a, input logic m);
        logic [95:0] rg, ra, rm;
        logic kg, ka, km;
        rg = {xs(), xs(), xs()};
        ra = {xs(), xs(), xs()};
        rm = {xs(), xs(), xs()};
        kg = g & capt[SFQ_GYR_EN] & ((gcnt % (1 << downs[2:0])) == 0);
        ka = a & capt[SFQ_ACC_EN] & ((acnt % (1 << downs[6:4])) == 0);
        km = m & capt[SFQ_MAG_EN];
        gcnt += int'(g & capt[SFQ_GYR_EN]);
        acnt += int'(a & capt[SFQ_ACC_EN]);
        if (capt[SFQ_HDR_EN] && (kg || ka || km))
            q.push_back({SFQ_HDR_DATA, km, kg, ka, capt[SFQ_TAG1_EN] & event_pin_one,
                capt[SFQ_TAG2_EN] & event_pin_two});
        push6(km, rm[47:0]);
        push6(kg, downs[SFQ_GYR_FILT] ? rg[95:48] : rg[47:0]);
        push6(ka, downs[SFQ_ACC_FILT] ? ra[95:48] : ra[47:0]);
        {gyr_filt, gyr_raw} <= rg;
        {acc_filt, acc_raw} <= ra;
        mag_data <= rm[47:0];
        {gyr_valid, acc_valid, mag_valid} <= {g, a, m};
        @(posedge hclk);
        {gyr_valid, acc_valid, mag_valid} <= 3'h0;
        repeat (24) @(posedge hclk);
    endtask : strobe
    task automatic drain();
        while (q.size() > 0)
            rd(SFQ_IDX_DATA, q.pop_front());
        rd(SFQ_IDX_DATA, SFQ_HDR_EMPTY);
    endtask : drain
    initial
    begin
        {hsel, hwrite, gyr_valid, acc_valid, mag_valid, event_pin_one, event_pin_two} = '0;
        {haddr, hwdata, htrans} = '0;
        {gyr_raw, gyr_filt, acc_raw, acc_filt, mag_data, sensor_time} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        {failures, samples_checked, gcnt, acnt} = '0;
        capt = 8'h10;
        downs = 8'h00;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(SFQ_IDX_DOWNS, 8'h00);
        rd(SFQ_IDX_THRESH, 8'h80);
        rd(SFQ_IDX_CAPT, 8'h10);
        rd(8'h10, 8'h00);
        t = xs();
        w8 = t[7:0];
        bus(1'b1, SFQ_IDX_THRESH, w8);
        rd(SFQ_IDX_THRESH, w8);
        downs = 8'h1a;
        capt = 8'hd8;
        event_pin_one <= 1'b1;
        bus(1'b1, SFQ_IDX_DOWNS, downs);
        bus(1'b1, SFQ_IDX_CAPT, capt);
        for (int i = 0; i < 4; i++)
            strobe(1'b1, 1'b1, i == 0);
        drain();
        capt = 8'h12;
        t = xs();
        sensor_time <= t[23:0];
        bus(1'b1, SFQ_IDX_CAPT, capt);
        strobe(1'b1, 1'b1, 1'b1);
        rd(SFQ_IDX_DATA, SFQ_HDR_TIME);
        for (int i = 0; i < 3; i++)
            rd(SFQ_IDX_DATA, sensor_time[8*i +: 8]);
        rd(SFQ_IDX_DATA, SFQ_HDR_EMPTY);
        downs = 8'h80;
        event_pin_two <= 1'b1;
        bus(1'b1, SFQ_IDX_DOWNS, downs);
        for (int i = 0; i < 2; i++)
        begin
            capt = (i == 0) ? 8'ha4 : 8'hfc;
            bus(1'b1, SFQ_IDX_CAPT, capt);
            strobe(1'b1, 1'b1, 1'b1);
        end
        drain();
        bus(1'b1, SFQ_IDX_THRESH, 8'h01);
        bus(1'b1, SFQ_IDX_STAT, 8'h07);
        capt = 8'h90;
        bus(1'b1, SFQ_IDX_CAPT, capt);
        strobe(1'b1, 1'b0, 1'b0);
        rd(SFQ_IDX_STAT, 8'h00);
        strobe(1'b1, 1'b0, 1'b0);
        rd(SFQ_IDX_STAT, 8'h01);
        rd(SFQ_IDX_LEVEL, 8'h01);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, SFQ_IDX_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, SFQ_IDX_MASK, 8'h00);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, SFQ_IDX_MASK, 8'h01);
        drain();
        bus(1'b1, SFQ_IDX_STAT, 8'h01);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        rd(SFQ_IDX_STAT, 8'h00);
        // A second strobe while the first frame is pushed is dropped and flagged.
        t = xs();
        q.push_back({SFQ_HDR_DATA, 5'b01000});
        push6(1'b1, {t[15:0], t});
        gyr_raw <= {t[15:0], t};
        gyr_valid <= 1'b1;
        repeat (2) @(posedge hclk);
        gyr_valid <= 1'b0;
        gcnt += 2;
        repeat (24) @(posedge hclk);
        rd(SFQ_IDX_STAT, 8'h04);
        drain();
        tally_and_finish();
    end
endmodule : sfq_capture_bench
